// *** odac_pkg.sv ***
// Package for the octal converter host controller: widths, codes, timing counts.
// Assumes a 200 MHz system clock.
package odac_pkg;
  localparam int unsigned CODE_W = 13;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned NUM_CH = 8;
  localparam logic [CODE_W-1:0] CODE_OFFSET = 13'h1000;
  localparam logic [CODE_W-1:0] CODE_MIN = 13'h0000;
  localparam logic [CODE_W-1:0] CODE_MAX = 13'h1fff;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned LOAD_GAP_PS = 50000;
  localparam int unsigned LOAD_GAP_CYC =
    (LOAD_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETUP_CYC = 2;
  localparam int unsigned STROBE_CYC = 4;
  localparam int unsigned HOLD_CYC = 2;
  localparam int unsigned LOAD_CYC = 4;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] LOAD_GAP_CNT = CNT_W'(LOAD_GAP_CYC);
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] LOAD_CNT = CNT_W'(LOAD_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ODAC_IDLE,
    ODAC_SETUP,
    ODAC_STROBE,
    ODAC_HOLD,
    ODAC_GAP,
    ODAC_LOAD
  } odac_state_e;

  // Signed two's-complement to offset binary
  function automatic logic [CODE_W-1:0] odac_to_offset(input logic [CODE_W-1:0] v,
                                                       input logic is_signed);
    odac_to_offset = is_signed ? CODE_W'(v + CODE_OFFSET) : v;
  endfunction : odac_to_offset
endpackage : odac_pkg

// *** odac_shadow_mem.sv ***
// Shadow memory of the last code written to each channel.
// Assumes one write port and a registered read port on clk_sys.
`timescale 1ns/100ps
module odac_shadow_mem
  import odac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_addr,
  input wire logic [CODE_W-1:0] wr_data,
  input wire logic [SEL_W-1:0] rd_addr,
  output logic [CODE_W-1:0] rd_data
);
  logic [CODE_W-1:0] mem_q [NUM_CH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule : odac_shadow_mem

// *** odac_host.sv ***
// Host controller driving the octal converter's parallel write bus.
// Assumes all inputs synchronous to clk_sys; pins go straight to the device.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Host sends offset binary, adds 4096 to signed codes
// - Load strobe falls only with stable data
// - Load falls 60ns after chip select rises
// - Hold logic outputs low until supplies ready
// - Select stable while select and write low
module odac_host
  import odac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic supply_ok,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [SEL_W-1:0] wr_chan,
  input wire logic [CODE_W-1:0] wr_code,
  input wire logic wr_signed,
  input wire logic wr_load,
  input wire logic direct_mode,
  input wire logic clear_req,
  input wire logic [SEL_W-1:0] rb_chan,
  output logic [CODE_W-1:0] rb_code,
  output logic [CODE_W-1:0] code_bus,
  output logic chan_sel_0,
  output logic chan_sel_1,
  output logic chan_sel_2,
  output logic chip_sel_n,
  output logic write_n,
  output logic load_strobe_n,
  output logic async_clear_n,
  output logic busy
);
  ////////////////////////////////////////////////////////////////////////////
  odac_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CODE_W-1:0] code_q;
  logic [SEL_W-1:0] sel_q;
  logic load_q, direct_q;
  logic cs_n_q, wr_n_q, ld_n_q, clr_n_q;
  logic [CODE_W-1:0] conv_code;
  logic accept, cnt_done, shadow_we;

  assign conv_code = odac_to_offset(wr_code, wr_signed);
  assign wr_ready = (state_q == ODAC_IDLE) && supply_ok;
  assign accept = wr_valid && wr_ready;
  assign cnt_done = (cnt_q == CNT_ONE);
  assign shadow_we = accept;
  assign busy = (state_q != ODAC_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q == CNT_ZERO) ? CNT_ZERO : cnt_q - CNT_ONE;
    case (state_q)
      ODAC_IDLE: begin
        if (accept) begin
          state_d = ODAC_SETUP;
          cnt_d = SETUP_CNT;
        end
      end
      ODAC_SETUP: begin
        if (cnt_done) begin
          state_d = ODAC_STROBE;
          cnt_d = STROBE_CNT;
        end
      end
      ODAC_STROBE: begin
        if (cnt_done) begin
          state_d = ODAC_HOLD;
          cnt_d = HOLD_CNT;
        end
      end
      ODAC_HOLD: begin
        if (cnt_done) begin
          state_d = load_q ? ODAC_GAP : ODAC_IDLE;
          cnt_d = LOAD_GAP_CNT;
        end
      end
      ODAC_GAP: begin
        if (cnt_done) begin
          state_d = ODAC_LOAD;
          cnt_d = LOAD_CNT;
        end
      end
      ODAC_LOAD: begin
        if (cnt_done) begin
          state_d = ODAC_IDLE;
        end
      end
      default: begin
        state_d = ODAC_IDLE;
        cnt_d = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_q <= ODAC_IDLE;
      cnt_q <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Captured request; channel and data stay fixed until idle again
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      code_q <= CODE_MIN;
      sel_q <= '0;
      load_q <= 1'b0;
      direct_q <= 1'b0;
    end else if (accept) begin
      code_q <= conv_code;
      sel_q <= wr_chan;
      load_q <= wr_load | direct_mode;
      direct_q <= direct_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; all low-active controls held low until supplies are up
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cs_n_q <= 1'b0;
      wr_n_q <= 1'b0;
      ld_n_q <= 1'b0;
      clr_n_q <= 1'b0;
    end else if (!supply_ok) begin
      cs_n_q <= 1'b0;
      wr_n_q <= 1'b0;
      ld_n_q <= 1'b0;
      clr_n_q <= 1'b0;
    end else begin
      cs_n_q <= !(state_d == ODAC_STROBE);
      wr_n_q <= !(state_d == ODAC_STROBE);
      ld_n_q <= !((state_d == ODAC_LOAD) ||
                  (direct_q && state_d == ODAC_STROBE));
      clr_n_q <= !clear_req;
    end
  end

  assign code_bus = (supply_ok && busy) ? code_q : CODE_MIN;
  assign chan_sel_0 = supply_ok & sel_q[0];
  assign chan_sel_1 = supply_ok & sel_q[1];
  assign chan_sel_2 = supply_ok & sel_q[2];
  assign chip_sel_n = cs_n_q;
  assign write_n = wr_n_q;
  assign load_strobe_n = ld_n_q;
  assign async_clear_n = clr_n_q;

  odac_shadow_mem u_shadow (
    .clk_sys(clk_sys),
    .wr_en(shadow_we),
    .wr_addr(wr_chan),
    .wr_data(conv_code),
    .rd_addr(rb_chan),
    .rd_data(rb_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cs_rise;
    $rose(chip_sel_n);
  endsequence
  // Ten quiet cycles, the 50ns minimum of the 12-cycle select-to-load gap
  sequence s_gap_quiet;
    load_strobe_n[*5] ##1 load_strobe_n[*5];
  endsequence

  AST_LOAD_GAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (supply_ok && !direct_q) and s_cs_rise |-> s_gap_quiet)
    else $error("load strobe fell too soon after chip select");
  AST_SEL_STABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    !chip_sel_n && !write_n && supply_ok && $past(supply_ok) && $past(!chip_sel_n)
    |-> $stable({chan_sel_2, chan_sel_1, chan_sel_0}))
    else $error("channel select moved during write");
  AST_DATA_STABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(load_strobe_n) && supply_ok && $past(supply_ok) |-> $stable(code_bus))
    else $error("data moved as load strobe fell");
  AST_PWR_LOW: assert property (@(posedge clk_sys) disable iff (!nrst)
    !supply_ok && !$past(supply_ok) |-> !chip_sel_n && !write_n && !load_strobe_n
    && !async_clear_n && code_bus == CODE_MIN)
    else $error("logic pin high before supplies");
  AST_STROBE_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
    supply_ok && $fell(write_n) |-> (!write_n && !chip_sel_n)[*4] ##1 write_n)
    else $error("write strobe width wrong");
  AST_OFFSET: assert property (@(posedge clk_sys) disable iff (!nrst)
    accept && wr_signed |=> code_q == CODE_W'($past(wr_code) + CODE_OFFSET))
    else $error("signed code not offset");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    supply_ok && clear_req && $past(supply_ok) |=> !async_clear_n)
    else $error("clear not driven");
  AST_LOAD_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
    supply_ok && state_q == ODAC_GAP && cnt_done |=> !load_strobe_n[*4] ##1 load_strobe_n)
    else $error("load pulse wrong");
endmodule : odac_host

// *** odac_dev_model.sv ***
// Behavioural model of the octal converter's input latches, output latches and clear.
// Assumes its pins come straight from the host controller; ground sense is a code.
`timescale 1ns/100ps
module odac_dev_model
  import odac_pkg::*;
(
  input wire logic [CODE_W-1:0] code_bus,
  input wire logic chan_sel_0,
  input wire logic chan_sel_1,
  input wire logic chan_sel_2,
  input wire logic chip_sel_n,
  input wire logic write_n,
  input wire logic load_strobe_n,
  input wire logic async_clear_n,
  input wire logic [CODE_W-1:0] output_ground_sense,
  output logic [NUM_CH-1:0][CODE_W-1:0] in_lat,
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_lat,
  output logic [NUM_CH-1:0][CODE_W-1:0] dac_out,
  output int n_deglitch,
  output logic gap_ok
);
  wire logic [SEL_W-1:0] sel = {chan_sel_2, chan_sel_1, chan_sel_0};
  realtime t_cs = 0;
  initial begin
    in_lat = '0;
    dac_lat = '0;
    n_deglitch = 0;
    gap_ok = 1'b0;
  end
  always @* if (!chip_sel_n && !write_n) in_lat[sel] = code_bus;
  always @* if (!load_strobe_n) dac_lat = in_lat;
  always @* for (int i = 0; i < NUM_CH; i++) begin
    dac_out[i] = async_clear_n ? dac_lat[i] : output_ground_sense;
  end
  always @(posedge chip_sel_n) t_cs = $realtime;
  // Counts deglitch triggers and flags a select-to-load gap of at least 50ns
  always @(negedge load_strobe_n) begin
    n_deglitch++;
    gap_ok = ($realtime - t_cs) >= 50.0;
  end
endmodule : odac_dev_model

// *** tb.sv ***
// Self-checking bench for the octal converter host controller.
// Assumes the behavioural converter model on the far side of the pins.
`timescale 1ns/100ps
module tb;
  import odac_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, supply_ok = 1'b1, wr_valid = 1'b0, wr_signed = 1'b0;
  logic wr_load = 1'b0, direct_mode = 1'b0, clear_req = 1'b0, gap_ok;
  logic [SEL_W-1:0] wr_chan = '0, rb_chan = '0;
  logic [CODE_W-1:0] wr_code = '0, rb_code, code_bus;
  logic wr_ready, chan_sel_0, chan_sel_1, chan_sel_2, chip_sel_n, write_n;
  logic load_strobe_n, async_clear_n, busy;
  logic [NUM_CH-1:0][CODE_W-1:0] in_lat, dac_lat, dac_out;
  int n_deglitch, n_mismatch = 0, compares = 0, cyc = 0, n_busy = 0;
  localparam logic [CODE_W-1:0] GND_CODE = 13'h0055;
  always #2.5 clk_sys = ~clk_sys;
  odac_host dut_u (.clk_sys, .nrst, .supply_ok, .wr_valid, .wr_ready, .wr_chan, .wr_code,
    .wr_signed, .wr_load, .direct_mode, .clear_req, .rb_chan, .rb_code, .code_bus,
    .chan_sel_0, .chan_sel_1, .chan_sel_2, .chip_sel_n, .write_n, .load_strobe_n,
    .async_clear_n, .busy);
  odac_dev_model dev_u (.code_bus, .chan_sel_0, .chan_sel_1, .chan_sel_2, .chip_sel_n,
    .write_n, .load_strobe_n, .async_clear_n, .output_ground_sense(GND_CODE), .in_lat,
    .dac_lat, .dac_out, .n_deglitch, .gap_ok);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [CODE_W-1:0] exp, input logic [CODE_W-1:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [SEL_W-1:0] ch, input logic [CODE_W-1:0] c, input logic sg,
                    input logic ld, input logic dm);
    @(negedge clk_sys);
    while (wr_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_chan <= ch;
    wr_code <= c;
    wr_signed <= sg;
    wr_load <= ld;
    direct_mode <= dm;
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    n_busy = 0;
    do begin
      @(negedge clk_sys);
      if (busy === 1'b1) n_busy++;
    end while (busy !== 1'b0);
  endtask : wr
  task automatic sc_load_all;
    logic [CODE_W-1:0] c;
    int d;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      c = 13'h0123 + CODE_W'(ch * 13'h0400);
      d = n_deglitch;
      wr(SEL_W'(ch), c, 1'b0, 1'b1, 1'b0);
      chk("output latch", c, dac_out[ch]);
      chk("deglitch", 13'h0001, CODE_W'(n_deglitch - d));
      chk("load gap", 13'h0001, CODE_W'(gap_ok));
      chk("busy cycles", CODE_W'(SETUP_CYC + STROBE_CYC + HOLD_CYC + LOAD_GAP_CYC + LOAD_CYC),
        CODE_W'(n_busy));
      @(posedge clk_sys);
      rb_chan <= SEL_W'(ch);
      repeat (2) @(negedge clk_sys);
      chk("readback", c, rb_code);
    end
  endtask : sc_load_all
  task automatic sc_hold_clear;
    wr(3'h2, 13'h0abc, 1'b0, 1'b0, 1'b0);
    chk("busy cycles", CODE_W'(SETUP_CYC + STROBE_CYC + HOLD_CYC), CODE_W'(n_busy));
    chk("input latch", 13'h0abc, in_lat[2]);
    chk("held output", 13'h0923, dac_out[2]);
    @(posedge clk_sys);
    clear_req <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("clear pin", 13'h0000, CODE_W'(async_clear_n));
    for (int i = 0; i < NUM_CH; i++) chk("cleared", GND_CODE, dac_out[i]);
    chk("kept input", 13'h0abc, in_lat[2]);
    chk("kept output", 13'h0923, dac_lat[2]);
    @(posedge clk_sys);
    clear_req <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("restored", 13'h0923, dac_out[2]);
  endtask : sc_hold_clear
  task automatic sc_codes;
    logic [2*CODE_W:0] tbl [5] = '{{1'b0, 13'h0000, 13'h0000}, {1'b0, 13'h1fff, 13'h1fff},
      {1'b1, 13'h1fff, 13'h0fff}, {1'b1, 13'h1000, 13'h0000}, {1'b1, 13'h0fff, 13'h1fff}};
    int d;
    foreach (tbl[i]) begin
      wr(3'h5, tbl[i][2*CODE_W-1:CODE_W], tbl[i][2*CODE_W], 1'b1, 1'b0);
      chk("code map", tbl[i][CODE_W-1:0], dac_out[5]);
    end
    d = n_deglitch;
    wr(3'h6, 13'h1555, 1'b0, 1'b0, 1'b1);
    chk("direct drive", 13'h1555, dac_out[6]);
    chk("direct deglitch", 13'h0002, CODE_W'(n_deglitch - d));
  endtask : sc_codes
  task automatic sc_supply;
    @(posedge clk_sys);
    supply_ok <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("bus unpowered", 13'h0000, code_bus);
    chk("pins unpowered", 13'h0000, CODE_W'({chip_sel_n, write_n, load_strobe_n,
      async_clear_n, wr_ready, chan_sel_2, chan_sel_1, chan_sel_0}));
    @(posedge clk_sys);
    supply_ok <= 1'b1;
  endtask : sc_supply
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    sc_load_all();
    sc_hold_clear();
    sc_codes();
    sc_supply();
    give_verdict();
  end
endmodule : tb
